/* core/scf_pkg.sv */
// Purpose: Constants for the SPI 3-bit CRC framing and status block
// Assumes: 32-bit frames, MSB first, one system clock of 250 MHz
// Notes:   Register offsets are byte addresses of 32-bit words
//
// Functional notes
// - CRC over all 32 command bits, fed MSB first as they arrive.
// - Bad command CRC: command dropped, serial-interface error response sent.
// - Checker shift register preset from the 3-bit configured seed.
// - Message and CRC shifted through; zero remainder valid, nonzero corrupt.
// - Both directions use x^3+x+1 with non-direct configured seed.
// - Response CRC over 29 response bits, seeded, message MSB first.
// - Three zero bits follow the message; final register is sent CRC.
// - With CRC mode on, sensor data responses carry a 4-bit counter.
// - One counter per source identifier, advanced on its responses, starts 0001.
// - Seed 111 reproduces example vectors; CRC fills bits 2 to 0.
// - Basic status sampled at slave select rising edge of previous command.
// - Register status: error 11, self-test 10, init 00, normal 01.
// - Sensor responses: self-test of addressed channel; detail 00, data unchanged.
// - Alternative status bit: same codes and priorities, other error detail.
package scf_pkg;
  // ==========================================================
  // Frame layout
  localparam int          FRAME_BITS   = 32;
  localparam logic [5:0]  FRAME_LAST   = 6'h20;
  localparam int          CMD_MSB      = 31;
  localparam int          CMD_LSB      = 28;
  localparam int          ST_LSB       = 26;
  localparam int          SD_LSB       = 14;
  localparam int          SF_LSB       = 8;
  localparam int          KAC_LSB      = 4;
  localparam int          RD_LSB       = 8;
  localparam logic [2:0]  CRC_POLY     = 3'h3;    // x^3 + x + 1
  localparam logic [2:0]  CRC_ZERO     = 3'h0;
  localparam logic [3:0]  KAC_INIT     = 4'h1;

  // ==========================================================
  // Basic status codes
  localparam logic [1:0]  ST_INIT      = 2'h0;
  localparam logic [1:0]  ST_NORMAL    = 2'h1;
  localparam logic [1:0]  ST_SELFTEST  = 2'h2;
  localparam logic [1:0]  ST_ERROR     = 2'h3;
  localparam logic [1:0]  SF_CLEAR     = 2'h0;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_CFG     = 8'h00;
  localparam logic [7:0]  ADDR_STEST   = 8'h04;
  localparam logic [7:0]  ADDR_ISTAT   = 8'h08;
  localparam logic [7:0]  ADDR_IMASK   = 8'h0C;
  localparam logic [7:0]  ADDR_LASTCMD = 8'h10;
  localparam logic [7:0]  ADDR_STATE   = 8'h14;
  // Config fields: seed [2:0], alt [3], crc_en [4], init [5]
  localparam int          CFG_ALT      = 3;
  localparam int          CFG_CRCEN    = 4;
  localparam int          CFG_INIT     = 5;
  localparam logic [5:0]  CFG_RESET    = 6'h17;   // seed 111, CRC on
  // Interrupt bits: [0] frame done, [1] CRC/frame error
  localparam int          IRQ_FRAME    = 0;
  localparam int          IRQ_CRCERR   = 1;

  // ==========================================================
  // One serial step of the CRC register, data rotated into LSB
  function automatic logic [2:0] crc3_step(input logic [2:0] r,
                                           input logic       d);
    crc3_step = {r[1:0], d} ^ (r[2] ? CRC_POLY : CRC_ZERO);
  endfunction

  // Response CRC: 29 message bits then three zeros
  function automatic logic [2:0] crc3_word(input logic [31:0] w,
                                           input logic [2:0]  seed);
    logic [2:0] r;
    r = seed;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      r = crc3_step(r, (i > 2) ? w[i] : 1'b0);
    end
    crc3_word = r;
  endfunction
endpackage

/* core/scf_crc3_serial.sv */
// Purpose: Serial 3-bit CRC checker for incoming command bits
// Assumes: shift_in pulses once per received bit, MSB first
// Notes:   Remainder of zero after 32 bits means a clean command
module scf_crc3_serial
  import scf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       load_in,
  input  wire logic [2:0] seed_in,
  input  wire logic       shift_in,
  input  wire logic       bit_in,
  output logic      [2:0] rem_out
);
  // ==========================================================
  // Shift register, preset at frame start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rem_out <= CRC_ZERO;
    end else if (load_in) begin
      rem_out <= seed_in;
    end else if (shift_in) begin
      rem_out <= crc3_step(rem_out, bit_in);
    end
  end
endmodule

/* core/scf_top.sv */
// Purpose: SPI slave framing with 3-bit CRC, status and message counter
// Assumes: SPI mode 0 pins sampled by clk_in far faster than sclk
// Notes:   Each response answers the previous frame (pipelined)
//
// The address map and the Wishbone interface to the registers were left to the implementer.
module scf_top
  import scf_pkg::*;
#(
  parameter int NUM_SRC = 8
)(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Wishbone classic slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out,
  // SPI pins
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_ss_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  // Device side
  input  wire logic [11:0] sensor_ch0_in,
  input  wire logic [11:0] sensor_ch1_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        internal_error_in,
  input  wire logic [1:0]  err_detail_in,
  input  wire logic [1:0]  err_detail_alt_in,
  output logic             cmd_valid_out,
  output logic      [31:0] cmd_word_out
);
  import scf_pkg::*;

  // ==========================================================
  // Pin synchronisers, then a third stage on sclk and select for edge detection
  logic [2:0] sclk_sy_r;
  logic [2:0] ss_sy_r;
  logic [1:0] mosi_sy_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_sy_r <= 3'h0;
      ss_sy_r   <= 3'h7;
      mosi_sy_r <= 2'h0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[1:0], spi_sclk_in};
      ss_sy_r   <= {ss_sy_r[1:0], spi_ss_n_in};
      mosi_sy_r <= {mosi_sy_r[0], spi_mosi_in};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  logic sel_act;
  assign sclk_rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  assign sclk_fall = ~sclk_sy_r[1] & sclk_sy_r[2];
  assign ss_fall   = ~ss_sy_r[1] & ss_sy_r[2];
  assign ss_rise   = ss_sy_r[1] & ~ss_sy_r[2];
  assign sel_act   = ~ss_sy_r[1];

  // ==========================================================
  // Configuration and status registers
  logic [5:0]  cfg_r;
  logic [7:0]  self_test_control_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [31:0] last_cmd_r;
  logic [1:0]  basic_status_field_r;
  logic [2:0]  crc_seed_field;
  logic        alt_status;
  logic        crc_en;
  logic        init_complete_flag;
  assign crc_seed_field     = cfg_r[2:0];
  assign alt_status         = cfg_r[CFG_ALT];
  assign crc_en             = cfg_r[CFG_CRCEN];
  assign init_complete_flag = cfg_r[CFG_INIT];

  logic wb_hit;
  logic wb_wr;
  assign wb_hit = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // Writes land on the edge where the master sees ack high
  assign wb_wr  = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in &
                  wb_sel_in[0];

  // ==========================================================
  // Bus answer one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_hit;
      if (wb_hit) begin
        case (wb_adr_in)
          ADDR_CFG:     wb_dat_out <= {26'h0, cfg_r};
          ADDR_STEST:   wb_dat_out <= {24'h0, self_test_control_r};
          ADDR_ISTAT:   wb_dat_out <= {30'h0, irq_stat_r};
          ADDR_IMASK:   wb_dat_out <= {30'h0, irq_mask_r};
          ADDR_LASTCMD: wb_dat_out <= last_cmd_r;
          ADDR_STATE:   wb_dat_out <= {30'h0, basic_status_field_r};
          default:      wb_dat_out <= 32'h0;
        endcase
      end
    end
  end

  // Writable control registers, low byte lane only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r               <= CFG_RESET;
      self_test_control_r <= 8'h0;
      irq_mask_r          <= 2'h0;
    end else if (wb_wr) begin
      case (wb_adr_in)
        ADDR_CFG:   cfg_r               <= wb_dat_in[5:0];
        ADDR_STEST: self_test_control_r <= wb_dat_in[7:0];
        ADDR_IMASK: irq_mask_r          <= wb_dat_in[1:0];
        default:    cfg_r               <= cfg_r;
      endcase
    end
  end

  // ==========================================================
  // Receive shift register and bit counter
  logic [31:0] rx_r;
  logic [5:0]  bit_cnt_r;
  logic        rx_shift;
  assign rx_shift = sel_act & sclk_rise;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_r      <= 32'h0;
      bit_cnt_r <= 6'h0;
    end else if (ss_fall) begin
      bit_cnt_r <= 6'h0;
    end else if (rx_shift) begin
      rx_r      <= {rx_r[30:0], mosi_sy_r[1]};  // MSB first
      // Saturate past the frame length so long frames are refused
      if (bit_cnt_r != '1) begin
        bit_cnt_r <= bit_cnt_r + 6'h1;
      end
    end
  end

  // Serial checker runs alongside the receiver
  logic [2:0] chk_rem;
  scf_crc3_serial u_chk (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (ss_fall),
    .seed_in  (crc_seed_field),
    .shift_in (rx_shift),
    .bit_in   (mosi_sy_r[1]),
    .rem_out  (chk_rem)
  );

  // ==========================================================
  // Frame verdict at slave select release
  logic       frame_ok;
  logic       is_sensor;
  logic [2:0] source_identifier;
  logic       chan;
  assign frame_ok = (bit_cnt_r == FRAME_LAST) &&
                    (!crc_en || chk_rem == CRC_ZERO);
  assign is_sensor         = rx_r[CMD_LSB];
  assign source_identifier = rx_r[CMD_MSB:CMD_LSB+1];
  assign chan              = rx_r[CMD_LSB+1];

  // Status priority: error, self-test, init, normal
  function automatic logic [1:0] basic_code(input logic err,
                                            input logic stest,
                                            input logic init);
    if (err)        basic_code = ST_ERROR;
    else if (stest) basic_code = ST_SELFTEST;
    else if (!init) basic_code = ST_INIT;
    else            basic_code = ST_NORMAL;
  endfunction

  logic       stest_any;
  logic       stest_chan;
  logic [1:0] st_reg;
  logic [1:0] st_sen;
  logic [1:0] detailed_status_field;
  assign stest_any  = |self_test_control_r;
  assign stest_chan = chan ? |self_test_control_r[7:4]
                           : |self_test_control_r[3:0];
  // Alternative mapping keeps codes; only error detail changes
  assign st_reg = basic_code(internal_error_in, stest_any,
                             init_complete_flag);
  assign st_sen = basic_code(internal_error_in, stest_chan,
                             init_complete_flag);
  assign detailed_status_field = !internal_error_in ? SF_CLEAR :
                                 alt_status ? err_detail_alt_in
                                            : err_detail_in;

  // ==========================================================
  // Per-source message counters
  logic [3:0] message_counter_r [NUM_SRC];
  logic       kac_adv;
  assign kac_adv = ss_rise & frame_ok & is_sensor & crc_en;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        message_counter_r[i] <= KAC_INIT;
      end
    end else if (kac_adv) begin
      // Plain 4-bit add wraps 1111 to 0000
      message_counter_r[source_identifier] <=
        message_counter_r[source_identifier] + 4'h1;
    end
  end

  // ==========================================================
  // Response word assembly for the next frame
  logic [31:0] resp_nxt;
  logic [31:0] body;
  logic [3:0]  echo;
  logic [11:0] sd;
  always_comb begin
    echo = {rx_r[CMD_LSB], rx_r[CMD_MSB:CMD_LSB+1]};
    sd   = chan ? sensor_ch1_in : sensor_ch0_in;
    body = 32'h0;
    if (!frame_ok) begin
      // Bad CRC or length: error frame, command echo cleared
      body[ST_LSB+1:ST_LSB] = ST_ERROR;
    end else if (is_sensor) begin
      body[CMD_MSB:CMD_LSB]  = echo;
      body[ST_LSB+1:ST_LSB]  = st_sen;
      body[SD_LSB+11:SD_LSB] = sd;
      body[SF_LSB+1:SF_LSB]  = detailed_status_field;
      if (crc_en) begin
        body[KAC_LSB+3:KAC_LSB] =
          message_counter_r[source_identifier];
      end
    end else begin
      body[CMD_MSB:CMD_LSB] = echo;
      body[ST_LSB+1:ST_LSB] = st_reg;
      body[RD_LSB+15:RD_LSB] = reg_rdata_in;
    end
    resp_nxt = body;
    if (crc_en) begin
      resp_nxt[2:0] = crc3_word(body, crc_seed_field);
    end
  end

  // ==========================================================
  // Latch response, status and events at slave select release
  logic [31:0] tx_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_r                 <= 32'h0;
      basic_status_field_r <= ST_INIT;
      last_cmd_r           <= 32'h0;
      cmd_valid_out        <= 1'b0;
      cmd_word_out         <= 32'h0;
    end else begin
      cmd_valid_out <= ss_rise & frame_ok;
      if (ss_rise) begin
        tx_r                 <= resp_nxt;
        basic_status_field_r <= resp_nxt[ST_LSB+1:ST_LSB];
        last_cmd_r           <= rx_r;
        if (frame_ok) begin
          cmd_word_out <= rx_r;
        end
      end
    end
  end

  // ==========================================================
  // Transmit: first bit at select fall, then on each sclk fall
  logic [31:0] tx_sh_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_r      <= 32'h0;
      spi_miso_out <= 1'b0;
    end else if (ss_fall) begin
      tx_sh_r      <= {tx_r[30:0], 1'b0};
      spi_miso_out <= tx_r[31];
    end else if (sel_act && sclk_fall) begin
      tx_sh_r      <= {tx_sh_r[30:0], 1'b0};
      spi_miso_out <= tx_sh_r[31];
    end
  end

  // ==========================================================
  // Sticky events, write one to clear; a new event beats the clear
  logic [1:0] ev;
  logic [1:0] w1c;
  assign ev[IRQ_FRAME]  = ss_rise & frame_ok;
  assign ev[IRQ_CRCERR] = ss_rise & ~frame_ok;
  assign w1c = (wb_wr && wb_adr_in == ADDR_ISTAT) ? wb_dat_in[1:0] : 2'h0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= 2'h0;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      irq_out    <= |(((irq_stat_r & ~w1c) | ev) & irq_mask_r);
    end
  end
endmodule

/* test/scf_host_model.sv */
// Purpose: SPI mode 0 host that sends frames of up to 32 bits and catches replies
// Assumes: half period hp given in clk_in cycles, at least 4
// Notes:   a released mosi shows the inverted last bit, never a stale one
module scf_host_model (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      ss_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Idle bus: clock low, deselected
  initial begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ==========
  // One frame of nb bits, MSB first; reply bit caught at sclk rise
  task automatic xfer(input logic [31:0] cmd, input int nb,
                      input int hp, output logic [31:0] rsp);
    rsp = 32'h0;
    @(posedge clk_in);
    ss_n_out <= 1'b0;
    mosi_out <= cmd[31];
    repeat (hp) @(posedge clk_in);
    for (int i = 31; i > 31 - nb; i--) begin
      sclk_out <= 1'b1;
      rsp[i] = miso_in;
      repeat (hp) @(posedge clk_in);
      sclk_out <= 1'b0;
      if (i > 0) mosi_out <= cmd[i-1];
      repeat (hp) @(posedge clk_in);
    end
    ss_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

/* test/scf_top_properties.sv */
// Purpose: Port-level properties of the SPI CRC framing block
// Assumes: one clock domain, async active-low reset
// Notes:   config and mask are shadowed from bus writes
module scf_top_checker
  import scf_pkg::*;
#(
  parameter int NUM_SRC = 8
)(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        irq_out,
  input wire logic        spi_ss_n_in,
  input wire logic        spi_sclk_in,
  input wire logic        spi_miso_out,
  input wire logic        cmd_valid_out,
  input wire logic [31:0] cmd_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cfg_r;
  logic [1:0] mask_r;
  logic       wr_ok;
  logic       mask_zero;
  assign wr_ok = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out
                 && wb_sel_in[0];
  assign mask_zero = (mask_r == 2'h0);
  // ==========
  // Shadows change only where a write takes effect
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r  <= CFG_RESET;
      mask_r <= 2'h0;
    end else if (wr_ok && wb_adr_in == ADDR_CFG) begin
      cfg_r <= wb_dat_in[5:0];
    end else if (wr_ok && wb_adr_in == ADDR_IMASK) begin
      mask_r <= wb_dat_in[1:0];
    end
  end
  // Own serial remainder, kept apart from the design's helper
  function automatic logic [2:0] rem3(input logic [31:0] w,
                                      input logic [2:0]  s);
    rem3 = s;
    for (int i = 31; i >= 0; i--) begin
      rem3 = {rem3[1:0], w[i]} ^ (rem3[2] ? 3'h3 : 3'h0);
    end
  endfunction
  // ==========
  // Properties
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("bus request not answered");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in
    && wb_adr_in >= 8'h18 |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (wb_ack_out && !wb_we_in
    && wb_adr_in == ADDR_CFG |-> wb_dat_out == {26'h0, cfg_r})
    else $error("config read wrong");
  a_irq_masked: assert property (mask_zero && $past(mask_zero)
    |-> !irq_out) else $error("interrupt while masked");
  a_valid_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command pulse too long");
  a_valid_framed: assert property (cmd_valid_out |-> spi_ss_n_in
    && $past(spi_ss_n_in, 2)) else $error("command judged in frame");
  a_word_with_valid: assert property ($changed(cmd_word_out)
    |-> cmd_valid_out) else $error("command word changed alone");
  a_good_crc: assert property (cmd_valid_out && cfg_r[4]
    |-> rem3(cmd_word_out, cfg_r[2:0]) == 3'h0)
    else $error("command with bad remainder accepted");
  a_miso_on_low: assert property ($changed(spi_miso_out)
    && !spi_ss_n_in |-> !spi_sclk_in)
    else $error("reply bit moved while clock high");
endmodule
bind scf_top scf_top_checker #(.NUM_SRC(NUM_SRC)) i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .irq_out(irq_out), .spi_ss_n_in(spi_ss_n_in),
  .spi_sclk_in(spi_sclk_in), .spi_miso_out(spi_miso_out),
  .cmd_valid_out(cmd_valid_out), .cmd_word_out(cmd_word_out)
);

/* test/spi_crc3_status_framing_test.sv */
// Purpose: Self-checking bench for the SPI CRC framing block
// Assumes: host model drives SPI, bench drives the register bus
// Notes:   replies are pipelined, so each frame checks the one before
module spi_crc3_status_framing_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scf_pkg::*;
  logic        clk_in, rst_n_in, cyc, stb, we, ierr, init, alt;
  logic        sclk, ss_n, mosi, miso, irq, ack, vld;
  logic        cen, exp_ce;
  logic [1:0]  ed, eda;
  logic [2:0]  sd, exp_sd;
  logic [3:0]  sel;
  logic [3:0]  cnt [8];
  logic [7:0]  adr, stc;
  logic [11:0] s0, s1;
  logic [15:0] rd;
  logic [31:0] wdat, rdat, cw, exp_w, msk, last, q, c;
  logic [63:0] r64;
  logic [31:0] tv [7] = '{32'h8022C104, 32'h401FC102, 32'hC0220001,
    32'h601FC100, 32'h40FF5A00, 32'hC03E0005, 32'h60FF5A02};
  int          seed = 32'h3d59ae07;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_ok = 0;
  int          n_vld = 0;
  // ==========
  // Clock, device and host
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  scf_top i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .irq_out(irq), .spi_sclk_in(sclk), .spi_ss_n_in(ss_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .sensor_ch0_in(s0),
    .sensor_ch1_in(s1), .reg_rdata_in(rd), .internal_error_in(ierr),
    .err_detail_in(ed), .err_detail_alt_in(eda), .cmd_valid_out(vld),
    .cmd_word_out(cw)
  );
  scf_host_model i_host (
    .clk_in(clk_in), .sclk_out(sclk), .ss_n_out(ss_n),
    .mosi_out(mosi), .miso_in(miso)
  );
  // Accepted-command pulses seen on the port
  always @(posedge clk_in) begin
    if (vld === 1'b1) n_vld++;
  end
  // ==========
  // Helpers
  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  // Serial x^3+x+1 register, new bits rotated in at the low end
  function automatic logic [2:0] crc3(input logic [31:0] w,
                                      input logic [2:0]  s);
    crc3 = s;
    for (int i = 31; i >= 0; i--) begin
      crc3 = {crc3[1:0], w[i]} ^ (crc3[2] ? 3'h3 : 3'h0);
    end
  endfunction
  // Error first, then self-test, then init state
  function automatic logic [1:0] st_of(input logic sn, input logic ch);
    logic t;
    t = sn ? (ch ? |stc[7:4] : |stc[3:0]) : |stc;
    st_of = ierr ? 2'h3 : t ? 2'h2 : init ? 2'h1 : 2'h0;
  endfunction
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int t;
    t = 0;
    @(posedge clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_in);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    if (t >= 20) begin
      n_errors++;
      give_verdict;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Send a frame, check the previous reply, predict this one
  task automatic frame(input logic [31:0] f, input int nb);
    logic [31:0] r;
    logic [3:0]  k;
    logic        ok;
    i_host.xfer(f, nb, 6 + 4 * ($random(seed) & 1), r);
    exp_w[2:0] = exp_ce ? crc3({r[31:3], 3'h0}, exp_sd) : 3'h0;
    if (msk != 32'h0) cmp("reply", exp_w & msk, r & msk);
    ok = (nb == 32) && (!cen || crc3(f, sd) == 3'h0);
    exp_sd = sd;
    exp_ce = cen;
    msk = 32'hFFFFFFFF;
    if (!ok) begin
      exp_w = {4'h0, 2'h3, 26'h0};
    end else if (f[28]) begin
      k = cen ? cnt[f[31:29]] : 4'h0;
      if (cen) cnt[f[31:29]] = k + 4'h1;
      exp_w = {f[28], f[31:29], st_of(1'b1, f[29]), f[29] ? s1 : s0,
               4'h0, ierr ? (alt ? eda : ed) : 2'h0, k, 4'h0};
      msk = 32'hFFFFC3F7;
    end else begin
      exp_w = {f[28], f[31:29], st_of(1'b0, 1'b0), 2'h0, rd, 8'h0};
    end
    if (ok) begin
      last = f;
      n_ok++;
    end
    cmp("command word", last, cw);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========
  // Watchdog, far beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk_in);
    n_errors++;
    give_verdict;
  end
  // ==========
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    {cyc, stb, we, ierr, init, alt} = 6'h0;
    {adr, stc, sel, ed, eda, s0, s1, rd, wdat} = '0;
    {sd, exp_sd, msk, last} = {3'h7, 3'h7, 32'h0, 32'h0};
    {cen, exp_ce} = 2'h3;
    foreach (cnt[i]) cnt[i] = 4'h1;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    wb(1'b0, ADDR_CFG, 32'h0, 4'hF);
    cmp("config reset", 32'h17, q);
    wb(1'b1, ADDR_CFG, 32'h30, 4'h0);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    cmp("unmapped read", 32'h0, q);
    wb(1'b0, ADDR_CFG, 32'h0, 4'hF);
    cmp("config no lanes", 32'h17, q);
    $display("test registers done");
    foreach (tv[i]) begin
      cmp("table crc", {29'h0, tv[i][2:0]},
          {29'h0, crc3(tv[i] & ~32'h7, 3'h7)});
      frame(tv[i], 32);
    end
    frame(tv[0] ^ 32'h1, 32);
    frame(tv[1], 31);
    frame(tv[2], 32);
    $display("test table done");
    wb(1'b1, ADDR_CFG, 32'h37, 4'hF);
    init = 1'b1;
    for (int k = 0; k < 48; k++) begin
      if (k == 30) begin
        {sd, alt} = {3'h5, 1'b1};
        wb(1'b1, ADDR_CFG, 32'h3D, 4'hF);
      end
      stc = (($random(seed) & 3) == 0) ? 8'($random(seed)) : 8'h0;
      wb(1'b1, ADDR_STEST, {24'h0, stc}, 4'hF);
      r64 = {$random(seed), $random(seed)};
      @(posedge clk_in);
      ierr <= (r64[63:62] == 2'h0);
      {ed, eda, s0, s1, rd} <= r64[43:0];
      c = {3'($random(seed)), 29'h0};
      if (k < 18) c = 32'hB0000000;
      else c[28] = 1'($random(seed));
      if (!c[28]) c[23:8] = 16'($random(seed));
      c[2:0] = crc3(c, sd) ^ {2'h0, r64[61:58] == 4'h0};
      frame(c, 32);
    end
    c = 32'h0;
    c[2:0] = crc3(c, sd);
    frame(c, 32);
    wb(1'b1, ADDR_CFG, 32'h2D, 4'hF);
    cen = 1'b0;
    frame(32'hB0000001, 32);
    frame(32'h5, 32);
    wb(1'b0, ADDR_LASTCMD, 32'h0, 4'hF);
    cmp("last frame", 32'h5, q);
    wb(1'b0, ADDR_STATE, 32'h0, 4'hF);
    cmp("last status", {30'h0, exp_w[27:26]}, q);
    cmp("valid pulses", n_ok, n_vld);
    $display("test random frames done");
    wb(1'b0, ADDR_ISTAT, 32'h0, 4'hF);
    cmp("irq status", 32'h3, q);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, ADDR_IMASK, 32'h1, 4'hF);
    repeat (3) @(posedge clk_in);
    cmp("irq raised", 32'h1, {31'h0, irq});
    wb(1'b1, ADDR_ISTAT, 32'h1, 4'hF);
    repeat (3) @(posedge clk_in);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    wb(1'b0, ADDR_ISTAT, 32'h0, 4'hF);
    cmp("irq status left", 32'h2, q);
    $display("test interrupts done");
    give_verdict;
  end
endmodule
